// >>> inc/sfcp_pkg.sv
// Constants, types and the opcode decoder of the serial flash command port.
package sfcp_pkg;

   // ************************************************************
   // Opcodes
   // ************************************************************
   localparam logic [7:0] OP_ARR_FAST = 8'h0B;
   localparam logic [7:0] OP_ARR_LEG  = 8'hE8;
   localparam logic [7:0] OP_ARR_LP   = 8'h01;
   localparam logic [7:0] OP_ARR_LF   = 8'h03;
   localparam logic [7:0] OP_PAGE_RD  = 8'hD2;
   localparam logic [7:0] OP_BUF1_RD  = 8'hD4;
   localparam logic [7:0] OP_BUF2_RD  = 8'hD6;
   localparam logic [7:0] OP_BUF1_LF  = 8'hD1;
   localparam logic [7:0] OP_BUF2_LF  = 8'hD3;
   localparam logic [7:0] OP_PROT_RD  = 8'h32;
   localparam logic [7:0] OP_SEC_RD   = 8'h77;
   localparam logic [7:0] OP_STAT_RD  = 8'hD7;
   localparam logic [7:0] OP_ID_RD    = 8'h9F;
   localparam logic [7:0] OP_XFER1    = 8'h60;
   localparam logic [7:0] OP_XFER2    = 8'h61;

   // ************************************************************
   // Header bytes after the opcode and other counts
   // ************************************************************
   localparam logic [2:0] HEAD_FAST   = 3'h4;
   localparam logic [2:0] HEAD_LEG    = 3'h7;
   localparam logic [2:0] HEAD_SLOW   = 3'h3;
   localparam logic [2:0] HEAD_PAGE   = 3'h7;
   localparam logic [2:0] HEAD_BUF    = 3'h4;
   localparam logic [2:0] HEAD_BUF_LF = 3'h3;
   localparam logic [2:0] HEAD_REG    = 3'h3;
   localparam logic [2:0] HEAD_NONE   = 3'h0;
   localparam logic [2:0] ADDR_BYTES  = 3'h3;
   localparam logic [2:0] BIT_LAST    = 3'h7;
   localparam logic [1:0] ID_LAST     = 2'h3;
   localparam int         STAT_RDY_BIT = 7;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {
      ST_OPC  = 2'h0,
      ST_HEAD = 2'h1,
      ST_DATA = 2'h3,
      ST_SKIP = 2'h2
   } sfcp_state_type;

   typedef enum logic [3:0] {
      K_NONE, K_ARRAY, K_PAGE, K_BUF, K_PROT, K_SEC, K_STAT, K_ID, K_XFER
   } sfcp_kind_type;

   typedef enum logic [1:0] {SP_ARRAY, SP_PROT, SP_SEC} sfcp_space_type;

   typedef struct packed {
      sfcp_kind_type kind;
      logic          sel;
      logic [2:0]    head;
   } sfcp_cmd_type;

   typedef struct packed {
      logic           rd;
      sfcp_space_type space;
      logic [23:0]    addr;
   } sfcp_core_req_type;

   localparam sfcp_cmd_type CMD_RESET = '{K_NONE, 1'h0, HEAD_NONE};

   function automatic sfcp_cmd_type sfcp_decode(input logic [7:0] op);
      sfcp_cmd_type c;
      c = CMD_RESET;
      case (op)
         OP_ARR_FAST: c = '{K_ARRAY, 1'h0, HEAD_FAST};
         OP_ARR_LEG:  c = '{K_ARRAY, 1'h0, HEAD_LEG};
         OP_ARR_LP:   c = '{K_ARRAY, 1'h0, HEAD_SLOW};
         OP_ARR_LF:   c = '{K_ARRAY, 1'h0, HEAD_SLOW};
         OP_PAGE_RD:  c = '{K_PAGE, 1'h0, HEAD_PAGE};
         OP_BUF1_RD:  c = '{K_BUF, 1'h0, HEAD_BUF};
         OP_BUF2_RD:  c = '{K_BUF, 1'h1, HEAD_BUF};
         OP_BUF1_LF:  c = '{K_BUF, 1'h0, HEAD_BUF_LF};
         OP_BUF2_LF:  c = '{K_BUF, 1'h1, HEAD_BUF_LF};
         OP_PROT_RD:  c = '{K_PROT, 1'h0, HEAD_REG};
         OP_SEC_RD:   c = '{K_SEC, 1'h0, HEAD_REG};
         OP_STAT_RD:  c = '{K_STAT, 1'h0, HEAD_NONE};
         OP_ID_RD:    c = '{K_ID, 1'h0, HEAD_NONE};
         OP_XFER1:    c = '{K_XFER, 1'h0, ADDR_BYTES};
         OP_XFER2:    c = '{K_XFER, 1'h1, ADDR_BYTES};
         default:     c = CMD_RESET;
      endcase
      return c;
   endfunction : sfcp_decode

endpackage : sfcp_pkg

// >>> rtl/sfcp_cmd_port.sv
// Serial command port of a page-erase serial flash, device side.
`timescale 1ns/1ns
`default_nettype none
module sfcp_cmd_port #(
   parameter int          PAGE_BYTES   = 256,
   parameter int          ARRAY_ADDR_W = 20,
   // Identification values are arbitrary.
   parameter logic [7:0]  MFR_ID       = 8'hA5,
   parameter logic [7:0]  DEV_ID1      = 8'h5A,
   parameter logic [7:0]  DEV_ID2      = 8'h3C
) (
   input  wire logic                            clk_i,
   input  wire logic                            reset_i,
   input  wire logic                            sck_i,
   input  wire logic                            cs_n_i,
   input  wire logic                            si_i,
   input  wire logic                            rst_n_pin_i,
   input  wire logic [7:0]                      core_data_i,
   output logic                                 so_o,
   output logic                                 so_oe_n_o,
   output logic                                 busy_o,
   output var sfcp_pkg::sfcp_core_req_type      core_req_o
);
   localparam int PW = $clog2(PAGE_BYTES);
   localparam logic [23:0] ARR_MASK = 24'((1 << ARRAY_ADDR_W) - 1);
   localparam logic [PW:0] X_END = (PW+1)'(PAGE_BYTES);
   localparam logic [PW-1:0] X_LAST = PW'(PAGE_BYTES - 1);

   if (PAGE_BYTES < 2 || PAGE_BYTES != (1 << PW) || ARRAY_ADDR_W > 24 || ARRAY_ADDR_W <= PW) begin : g_bad
      $error("Page size must be a power of two below the array size.");
   end

   // ************************************************************
   // Pin synchronisers and edge detection
   // ************************************************************
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic       sck_d_reg;
   logic       cs_d_reg;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sync1_reg <= 4'hE;
         sync2_reg <= 4'hE;
         sck_d_reg <= 1'h0;
         cs_d_reg  <= 1'h1;
      end else begin
         sync1_reg <= {rst_n_pin_i, cs_n_i, sck_i, si_i};
         sync2_reg <= sync1_reg;
         sck_d_reg <= sync2_reg[1];
         cs_d_reg  <= sync2_reg[2];
      end
   end

   wire si_s     = sync2_reg[0];
   wire sck_s    = sync2_reg[1];
   wire cs_n_s   = sync2_reg[2];
   wire pin_rst  = ~sync2_reg[3];
   // Edges count only while selected, so the idle level is free.
   wire sck_rise = sck_s & ~sck_d_reg & ~cs_n_s;
   wire sck_fall = ~sck_s & sck_d_reg & ~cs_n_s;
   wire cs_rise  = cs_n_s & ~cs_d_reg;
   wire abort    = cs_n_s | pin_rst;

   // ************************************************************
   // Command reception
   // ************************************************************
   sfcp_pkg::sfcp_state_type state_reg;
   sfcp_pkg::sfcp_state_type state_next;
   sfcp_pkg::sfcp_cmd_type   cmd_reg;
   logic [2:0]  bit_cnt_reg;
   logic [7:0]  in_sh_reg;
   logic [2:0]  head_cnt_reg;
   logic [23:0] addr_reg;
   logic        arm_reg;

   wire [7:0] in_next   = {in_sh_reg[6:0], si_s};
   wire       byte_done = sck_rise & (bit_cnt_reg == sfcp_pkg::BIT_LAST);
   wire       op_done   = byte_done & (state_reg == sfcp_pkg::ST_OPC);
   wire       in_head   = byte_done & (state_reg == sfcp_pkg::ST_HEAD);
   wire       head_last = in_head & (head_cnt_reg == cmd_reg.head - 3'h1);
   // Opcodes decode to kind, buffer and header length.
   wire sfcp_pkg::sfcp_cmd_type dec = sfcp_pkg::sfcp_decode(in_next);
   wire       no_addr   = (cmd_reg.kind == sfcp_pkg::K_PROT) | (cmd_reg.kind == sfcp_pkg::K_SEC);
   wire       addr_take = in_head & (head_cnt_reg < sfcp_pkg::ADDR_BYTES) & ~no_addr;
   wire       go_now    = op_done & (dec.kind != sfcp_pkg::K_NONE) & (dec.head == sfcp_pkg::HEAD_NONE);
   wire       go_head   = head_last & (cmd_reg.kind != sfcp_pkg::K_XFER);
   wire       go_data   = go_now | go_head;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         sfcp_pkg::ST_OPC: begin
            if (op_done) begin
               if (dec.kind == sfcp_pkg::K_NONE) begin
                  state_next = sfcp_pkg::ST_SKIP;
               end else if (dec.head == sfcp_pkg::HEAD_NONE) begin
                  state_next = sfcp_pkg::ST_DATA;
               end else begin
                  state_next = sfcp_pkg::ST_HEAD;
               end
            end
         end
         sfcp_pkg::ST_HEAD: begin
            if (head_last) begin
               state_next = go_head ? sfcp_pkg::ST_DATA : sfcp_pkg::ST_SKIP;
            end
         end
         sfcp_pkg::ST_DATA: state_next = sfcp_pkg::ST_DATA;
         sfcp_pkg::ST_SKIP: state_next = sfcp_pkg::ST_SKIP;
         default:           state_next = sfcp_pkg::ST_OPC;
      endcase
      if (abort) begin
         state_next = sfcp_pkg::ST_OPC;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg   <= sfcp_pkg::ST_OPC;
         bit_cnt_reg <= 3'h0;
      end else begin
         state_reg   <= state_next;
         bit_cnt_reg <= abort ? 3'h0 : bit_cnt_reg + {2'h0, sck_rise};
      end
   end

   // Input bits shift in only on a rising edge.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         in_sh_reg <= 8'h00;
      end else if (sck_rise) begin
         in_sh_reg <= in_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cmd_reg      <= sfcp_pkg::CMD_RESET;
         head_cnt_reg <= 3'h0;
      end else if (op_done) begin
         cmd_reg      <= dec;
         head_cnt_reg <= 3'h0;
      end else if (in_head) begin
         head_cnt_reg <= head_cnt_reg + 3'h1;
      end
   end

   // ************************************************************
   // Output stream
   // ************************************************************
   logic [7:0] out_sh_reg;
   logic [2:0] out_cnt_reg;
   logic       so_reg;
   logic       oe_n_reg;
   logic [7:0] data_reg;
   logic       have_reg;
   logic       fetch_reg;
   logic       pend_buf_reg;
   logic       pend_core_reg;
   logic       resp_core_reg;
   logic       tag_stream_reg;
   logic [1:0] id_idx_reg;
   logic       busy_reg;

   wire launch = sck_fall & (state_reg == sfcp_pkg::ST_DATA);
   wire load   = launch & (out_cnt_reg == 3'h0);
   wire k_arr  = cmd_reg.kind == sfcp_pkg::K_ARRAY;
   wire k_page = cmd_reg.kind == sfcp_pkg::K_PAGE;
   wire k_buf  = cmd_reg.kind == sfcp_pkg::K_BUF;
   wire k_stat = cmd_reg.kind == sfcp_pkg::K_STAT;
   wire stream_core = fetch_reg & (k_arr | k_page | no_addr);
   wire stream_buf  = fetch_reg & k_buf;
   wire stream_own  = fetch_reg & (k_stat | (cmd_reg.kind == sfcp_pkg::K_ID));
   wire [23:0] addr_inc  = addr_reg + 24'h000001;
   wire [23:0] addr_wrap = {addr_reg[23:PW], addr_inc[PW-1:0]};
   // Continuous reads run through the whole array and wrap.
   wire [23:0] addr_adv  = k_arr ? (addr_inc & ARR_MASK) : (no_addr ? addr_inc : addr_wrap);
   // Status shows ready while no transfer runs.
   wire [7:0] stat_byte = 8'(~busy_reg) << sfcp_pkg::STAT_RDY_BIT;
   wire [7:0] id_byte   = (id_idx_reg == 2'h0) ? MFR_ID :
                          (id_idx_reg == 2'h1) ? DEV_ID1 :
                          (id_idx_reg == 2'h2) ? DEV_ID2 : 8'h00;
   wire [7:0] buf_rdata;

   always_ff @(posedge clk_i) begin
      if (reset_i || op_done) begin
         addr_reg <= 24'h000000;
      end else if (addr_take) begin
         addr_reg <= {addr_reg[15:0], in_next};
      end else if (fetch_reg && !stream_own) begin
         addr_reg <= addr_adv;
      end
   end

   // Identification bytes step once per byte and then read zero.
   always_ff @(posedge clk_i) begin
      if (reset_i || op_done) begin
         id_idx_reg <= 2'h0;
      end else if (stream_own && id_idx_reg != sfcp_pkg::ID_LAST) begin
         id_idx_reg <= id_idx_reg + 2'h1;
      end
   end

   // A fetch is issued when the data phase opens and each time a byte leaves.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fetch_reg     <= 1'h0;
         pend_buf_reg  <= 1'h0;
         pend_core_reg <= 1'h0;
         resp_core_reg <= 1'h0;
      end else begin
         fetch_reg     <= (go_data | load) & ~abort;
         pend_buf_reg  <= stream_buf;
         pend_core_reg <= stream_core;
         resp_core_reg <= pend_core_reg;
      end
   end

   // Protection and security register reads come back through the core port like array bytes.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         data_reg <= 8'h00;
         have_reg <= 1'h0;
      end else if (stream_own) begin
         data_reg <= k_stat ? stat_byte : id_byte;
         have_reg <= 1'h1;
      end else if (pend_buf_reg) begin
         data_reg <= buf_rdata;
         have_reg <= 1'h1;
      end else if (resp_core_reg) begin
         data_reg <= core_data_i;
         have_reg <= 1'h1;
      end else if (load || abort) begin
         have_reg <= 1'h0;
      end
   end

   // Output bits launch only on a falling edge, MSB first.
   // The launch follows the edge by the synchroniser delay plus the output register.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         so_reg      <= 1'h0;
         out_sh_reg  <= 8'h00;
         out_cnt_reg <= 3'h0;
      end else if (load) begin
         so_reg      <= data_reg[7];
         out_sh_reg  <= {data_reg[6:0], 1'h0};
         out_cnt_reg <= sfcp_pkg::BIT_LAST;
      end else if (launch) begin
         so_reg      <= out_sh_reg[7];
         out_sh_reg  <= {out_sh_reg[6:0], 1'h0};
         out_cnt_reg <= out_cnt_reg - 3'h1;
      end else if (abort) begin
         out_cnt_reg <= 3'h0;
      end
   end

   // Output is released while deselected, driven from the first launch.
   always_ff @(posedge clk_i) begin
      if (reset_i || abort) begin
         oe_n_reg <= 1'h1;
      end else if (load) begin
         oe_n_reg <= 1'h0;
      end
   end

   // ************************************************************
   // Page to buffer transfer
   // ************************************************************
   logic [23:0]   x_base_reg;
   logic          x_sel_reg;
   logic [PW:0]   x_idx_reg;
   logic [PW-1:0] x_tag_reg;
   logic [PW-1:0] x_widx_reg;
   logic          x_resp_reg;
   sfcp_pkg::sfcp_core_req_type core_req_reg;

   // A stream fetch wins the core port; the transfer waits one cycle.
   wire x_go    = busy_reg & (x_idx_reg != X_END) & ~stream_core;
   wire x_start = cs_rise & arm_reg & ~pin_rst & ~busy_reg;
   wire x_wr    = x_resp_reg & busy_reg;

   always_ff @(posedge clk_i) begin
      if (reset_i || op_done || pin_rst) begin
         arm_reg <= 1'h0;
      end else if (head_last && cmd_reg.kind == sfcp_pkg::K_XFER) begin
         arm_reg <= 1'h1;
      end else if (cs_rise) begin
         arm_reg <= 1'h0;
      end
   end

   // The transfer starts when select rises after a full header.
   always_ff @(posedge clk_i) begin
      if (reset_i || pin_rst) begin
         busy_reg  <= 1'h0;
         x_idx_reg <= '0;
      end else if (x_start) begin
         busy_reg   <= 1'h1;
         x_idx_reg  <= '0;
         x_base_reg <= addr_reg & ARR_MASK;
         x_sel_reg  <= cmd_reg.sel;
      end else begin
         if (x_go) begin
            x_idx_reg <= x_idx_reg + (PW+1)'(1);
         end
         if (x_wr && x_widx_reg == X_LAST) begin
            busy_reg <= 1'h0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         core_req_reg   <= '0;
         tag_stream_reg <= 1'h0;
         x_tag_reg      <= '0;
         x_resp_reg     <= 1'h0;
         x_widx_reg     <= '0;
      end else begin
         core_req_reg.rd    <= stream_core | x_go;
         core_req_reg.space <= (cmd_reg.kind == sfcp_pkg::K_PROT) & stream_core ? sfcp_pkg::SP_PROT :
                               (cmd_reg.kind == sfcp_pkg::K_SEC) & stream_core ? sfcp_pkg::SP_SEC :
                               sfcp_pkg::SP_ARRAY;
         core_req_reg.addr  <= stream_core ? addr_reg : {x_base_reg[23:PW], x_idx_reg[PW-1:0]};
         tag_stream_reg     <= stream_core;
         x_tag_reg          <= x_idx_reg[PW-1:0];
         x_resp_reg         <= core_req_reg.rd & ~tag_stream_reg;
         x_widx_reg         <= x_tag_reg;
      end
   end

   // Buffer reads pick the buffer that the opcode names.
   sfcp_dual_buf #(
      .DEPTH     (PAGE_BYTES)
   ) u_buf (
      .clk_i     (clk_i),
      .wr_i      (x_wr),
      .wr_sel_i  (x_sel_reg),
      .wr_idx_i  (x_widx_reg),
      .wr_data_i (core_data_i),
      .rd_sel_i  (cmd_reg.sel),
      .rd_idx_i  (addr_reg[PW-1:0]),
      .rd_data_o (buf_rdata)
   );

   assign so_o       = so_reg;
   assign so_oe_n_o  = oe_n_reg;
   assign busy_o     = busy_reg;
   assign core_req_o = core_req_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_op(logic [7:0] op);
      op_done && in_next == op;
   endsequence

   chk_so_on_fall: assert property ($changed(so_reg) |-> $past(sck_fall))
      else $error("Serial output changed without a falling edge.");
   chk_in_on_rise: assert property ($changed(in_sh_reg) |-> $past(sck_rise))
      else $error("Input shifter moved without a rising edge.");
   chk_deselect_release: assert property (abort |=> so_oe_n_o && state_reg == sfcp_pkg::ST_OPC)
      else $error("Deselect did not release the output.");
   chk_byte_ready: assert property (load |-> have_reg)
      else $error("Byte launched before it was fetched.");
   chk_launch_cover: assert property (launch && !abort |=> $stable(out_cnt_reg) == 1'h0)
      else $error("Bit counter did not move on a launch.");
   chk_fast_read: assert property (s_op(sfcp_pkg::OP_ARR_FAST) or s_op(sfcp_pkg::OP_ARR_LEG)
      |=> cmd_reg.kind == sfcp_pkg::K_ARRAY && state_reg == sfcp_pkg::ST_HEAD)
      else $error("Continuous read opcode not decoded.");
   chk_slow_read: assert property (s_op(sfcp_pkg::OP_ARR_LF) or s_op(sfcp_pkg::OP_ARR_LP)
      |=> cmd_reg.kind == sfcp_pkg::K_ARRAY && cmd_reg.head == sfcp_pkg::HEAD_SLOW)
      else $error("Slow read opcode not decoded.");
   chk_page_read: assert property (s_op(sfcp_pkg::OP_PAGE_RD) |=> cmd_reg.kind == sfcp_pkg::K_PAGE)
      else $error("Page read opcode not decoded.");
   chk_buf_read: assert property (s_op(sfcp_pkg::OP_BUF2_RD) |=> k_buf && cmd_reg.sel)
      else $error("Second buffer read not decoded.");
   chk_buf_slow: assert property (s_op(sfcp_pkg::OP_BUF1_LF) |=> k_buf && !cmd_reg.sel)
      else $error("Slow first buffer read not decoded.");
   chk_reg_space: assert property (s_op(sfcp_pkg::OP_SEC_RD) |=> cmd_reg.kind == sfcp_pkg::K_SEC)
      else $error("Security register read not decoded.");
   chk_status_byte: assert property (s_op(sfcp_pkg::OP_STAT_RD)
      |=> fetch_reg ##1 data_reg == stat_byte)
      else $error("Status byte not fetched.");
   chk_xfer_start: assert property (x_start |=> busy_o ##1 core_req_o.rd)
      else $error("Transfer did not start.");
   chk_frame_end: assert property (cs_rise |=> bit_cnt_reg == 3'h0)
      else $error("Select rising did not end the command.");

endmodule : sfcp_cmd_port
`default_nettype wire

// >>> rtl/sfcp_dual_buf.sv
// Two SRAM data buffers with one write port and one registered read port.
`timescale 1ns/1ns
`default_nettype none
module sfcp_dual_buf #(
   parameter int DEPTH = 256
) (
   input  wire logic                     clk_i,
   input  wire logic                     wr_i,
   input  wire logic                     wr_sel_i,
   input  wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
   input  wire logic [7:0]               wr_data_i,
   input  wire logic                     rd_sel_i,
   input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
   output logic      [7:0]               rd_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [7:0] mem [2*DEPTH];

   if (DEPTH < 2 || DEPTH != (1 << AW)) begin : g_bad_depth
      $error("Buffer depth must be a power of two.");
   end

   // Read and write ports are separate, so a transfer never stalls a read.
   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         mem[{wr_sel_i, wr_idx_i}] <= wr_data_i;
      end
      rd_data_o <= mem[{rd_sel_i, rd_idx_i}];
   end

endmodule : sfcp_dual_buf
`default_nettype wire

// >>> tb/sfcp_cmd_port_tb.sv
// Self-checking bench of the serial flash command port.
`timescale 1ns/1ns
`default_nettype none
module sfcp_cmd_port_tb;
   localparam int PG = 16;
   logic       clk_i = 1'b0;
   logic       reset_i = 1'b1;
   logic       rst_n_pin_i = 1'b0;
   logic [7:0] core_data_i = 8'h00;
   wire logic  sck, cs_n, si, so_o, so_oe_n_o, busy_o;
   sfcp_pkg::sfcp_core_req_type core_req_o;
   logic [7:0] exp_q[$];
   logic [7:0] ops[8] = '{8'h0B, 8'hE8, 8'h01, 8'h03, 8'hD4, 8'hD6, 8'hD1, 8'hD3};
   int         hd[8] = '{5, 8, 4, 4, 5, 5, 4, 4};
   int         n_mismatch = 0;
   int         total_checks = 0;
   int         k, j, n;
   logic [23:0] a, b;
   always #5 clk_i = ~clk_i;
   sfcp_host_model u_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so_o), .so_oe_n_i(so_oe_n_o));
   sfcp_cmd_port #(.PAGE_BYTES(PG)) u_dut (.clk_i(clk_i), .reset_i(reset_i), .sck_i(sck), .cs_n_i(cs_n),
      .si_i(si), .rst_n_pin_i(rst_n_pin_i), .core_data_i(core_data_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
      .busy_o(busy_o), .core_req_o(core_req_o));
   // ****
   // Core model and checking
   // ****
   function automatic logic [7:0] pat(input logic [1:0] sp, input logic [23:0] ad);
      return ad[7:0] ^ ad[15:8] ^ ad[23:16] ^ {2'h0, sp, 4'h5};
   endfunction : pat
   // The core answers in the cycle after a request, where the port samples it.
   sfcp_pkg::sfcp_core_req_type req_q = '0;
   always @(negedge clk_i) begin
      req_q <= core_req_o;
      if (req_q.rd === 1'b1) core_data_i <= pat(req_q.space, req_q.addr);
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   always @(u_host.got_byte) begin
      if (exp_q.size() == 0) check("spare byte", u_host.rx_byte, ~u_host.rx_byte);
      else check("so byte", u_host.rx_byte, exp_q.pop_front());
   end
   task automatic wrap_up;
      if (exp_q.size() != 0) n_mismatch++;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic xf(input logic m3, input logic [63:0] tx, input int ntx, input int nrx, input logic oe);
      @(negedge clk_i);
      #2 u_host.frame(m3, tx, ntx, nrx);
      check("output enable", 8'(u_host.oe_seen), 8'(oe));
      repeat (8) @(negedge clk_i);
   endtask : xf
   initial begin
      #900000 n_mismatch++;
      wrap_up();
   end
   // ****
   // Scenarios
   // ****
   initial begin
      void'($urandom(32'hA91E1751));
      repeat (10) @(negedge clk_i);
      reset_i = 1'b0;
      // select stays high while the pin reset ends.
      rst_n_pin_i = 1'b1;
      repeat (4) @(negedge clk_i);
      // ready status in both modes, then the identity bytes.
      for (k = 0; k < 2; k++) begin
         exp_q = {8'h80, 8'h80};
         xf(k[0], {8'hD7, 56'h0}, 1, 2, 1'b1);
      end
      exp_q = {8'hA5, 8'h5A, 8'h3C, 8'h00};
      xf(1'b1, {8'h9F, 56'h0}, 1, 4, 1'b1);
      // every continuous read opcode, link clock far below both limits.
      for (k = 0; k < 4; k++) begin
         a = 24'($urandom) & 24'h0FFFF0;
         exp_q = {pat(2'h0, a), pat(2'h0, a + 24'h1)};
         xf(k[1], {ops[k], a, 32'h0}, hd[k], 2, 1'b1);
      end
      // protection and security spaces start at zero.
      for (k = 0; k < 2; k++) begin
         exp_q = {pat(2'(k + 1), 24'h0), pat(2'(k + 1), 24'h1)};
         xf(1'b0, {k ? 8'h77 : 8'h32, 56'h0}, 4, 2, 1'b1);
      end
      // page into each buffer, buffer reads wrap in the page.
      a = 24'($urandom) & 24'h0FFF00;
      // pin reset mid-transfer, select held high, ends the transfer.
      xf(1'b0, {8'h60, a, 32'h0}, 4, 0, 1'b0);
      check("busy", 8'(busy_o), 8'h01);
      rst_n_pin_i = 1'b0;
      repeat (4) @(negedge clk_i);
      check("busy after pin reset", 8'(busy_o), 8'h00);
      rst_n_pin_i = 1'b1;
      repeat (4) @(negedge clk_i);
      for (k = 4; k < 9; k++) begin
         b = a + 24'(k[0] * PG);
         if (k < 6) begin
            xf(1'b0, {8'h60 | 8'(k[0]), b, 32'h0}, 4, 0, 1'b0);
            check("busy", 8'(busy_o), 8'h01);
            for (n = 0; n < 300 && busy_o !== 1'b0; n++) @(negedge clk_i);
            if (n == 300) check("busy end", 8'(busy_o), 8'h00);
         end
         for (j = 0; j < 4; j++) exp_q.push_back(pat(2'h0, b + 24'((14 + j) % PG)));
         if (k < 8) xf(1'b0, {ops[k], 24'hE, 32'h0}, hd[k], 4, 1'b1);
         else xf(1'b1, {8'hD2, b + 24'hE, 32'h0}, 8, 4, 1'b1);
      end
      xf(1'b0, {8'hFF, 56'h0}, 2, 0, 1'b0);
      wrap_up();
   end
endmodule : sfcp_cmd_port_tb
`default_nettype wire

// >>> tb/sfcp_host_model.sv
// Behavioural SPI host that frames commands and collects returned bytes.
`timescale 1ns/1ns
`default_nettype none
module sfcp_host_model (
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      si_o,
   input  wire logic so_i,
   input  wire logic so_oe_n_i
);
   logic [7:0] rx_byte;
   logic       oe_seen;
   event       got_byte;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end
   // ****
   // Frame
   // ****
   // The model never programs or erases, so no rewrite falls due.
   // select falls at either idle level, opcode first.
   task automatic frame(input logic m3, input logic [63:0] tx, input int ntx, input int nrx);
      int i;
      sck_o = m3;
      #62 cs_n_o = 1'b0;
      si_o = tx[63];
      oe_seen = 1'b0;
      for (i = 0; i <= 8 * (ntx + nrx); i++) begin
         #43 sck_o = 1'b0;
         oe_seen = oe_seen | (i > 0 && so_oe_n_i === 1'b0);
         // capture on the falling edge after launch
         if (i > 8 * ntx) begin
            rx_byte = {rx_byte[6:0], so_i};
            if ((i - 8 * ntx) % 8 == 0) ->got_byte;
         end
         #62 sck_o = 1'b1;
         // Next bit leaves after the rising edge, held past the sampling clock; idle bits toggle.
         #20 si_o = (i + 1 < 8 * ntx) ? tx[62 - i] : ~si_o;
      end
      #43 sck_o = m3;
      #62 cs_n_o = 1'b1;
   endtask : frame
endmodule : sfcp_host_model
`default_nettype wire
